// file: verilog/cttc_pkg.sv
// package: register map, field layout and encodings of the compact timer control block
package cttc_pkg;
    // byte addresses on the apb bus
    localparam logic [7:0] CTRL_ONE_ADDR  = 8'h00;
    localparam logic [7:0] RUN_CTRL_ADDR  = 8'h04;
    localparam logic [7:0] CMP_A_ADDR     = 8'h08;
    localparam logic [7:0] CMP_P_ADDR     = 8'h0C;
    localparam logic [7:0] STATUS_ADDR    = 8'h10;
    localparam logic [7:0] COUNT_ADDR     = 8'h14;
    // control register fields
    localparam int MODE_MSB   = 7;
    localparam int MODE_LSB   = 6;
    localparam int ACT_MSB    = 5;
    localparam int ACT_LSB    = 4;
    localparam int INIT_BIT   = 3;
    localparam int POL_BIT    = 2;
    localparam int SWAP_BIT   = 1;
    localparam int CLRSEL_BIT = 0;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [9:0]  CMP_RESET   = 10'h000;
    localparam logic [2:0]  CMPP_RESET  = 3'h0;
    localparam logic [9:0]  COUNT_MAX   = 10'h3FF;
    localparam int          CMPP_SHIFT  = 7;
    typedef enum logic [1:0] {
        MODE_CMP  = 2'b00,
        MODE_UND  = 2'b01,
        MODE_PWM  = 2'b10,
        MODE_TMR  = 2'b11
    } cttc_mode_e;
    typedef enum logic [1:0] {
        ACT_NONE  = 2'b00,
        ACT_LOW   = 2'b01,
        ACT_HIGH  = 2'b10,
        ACT_TOG   = 2'b11
    } cttc_act_e;
    typedef struct packed {
        cttc_mode_e op_mode_sel;
        cttc_act_e  pin_action_sel;
        logic       pin_initial_level;
        logic       pin_polarity_invert;
        logic       period_duty_swap;
        logic       clear_source_sel;
    } cttc_ctrl_s;
endpackage

// file: verilog/cttc_top.sv
// compact 10-bit timer: control register, counter, comparators and output pin
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module cttc_top (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer pin and match events
    output logic             compare_output_pin,
    output logic             pin_enable,
    output logic             match_a_pulse,
    output logic             match_p_pulse
);
    cttc_pkg::cttc_ctrl_s ctrl_q;
    logic       counter_run_bit_q;
    logic       run_prev_q;
    logic [9:0] compare_a_value_q;
    logic [2:0] compare_p_value_q;
    logic [9:0] count_q;
    logic       level_q;
    logic       pwm_q;
    logic       hit_a_q;
    logic       hit_p_q;

    // register stage so prdata/pready come straight from flip-flops
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    assign addr_ok = (paddr == cttc_pkg::CTRL_ONE_ADDR) || (paddr == cttc_pkg::RUN_CTRL_ADDR)
                  || (paddr == cttc_pkg::CMP_A_ADDR)   || (paddr == cttc_pkg::CMP_P_ADDR)
                  || (paddr == cttc_pkg::STATUS_ADDR)  || (paddr == cttc_pkg::COUNT_ADDR);
    // one wait state: access phase answered on its second cycle
    assign wr_en = psel && penable && pready && pwrite && addr_ok;
    assign rd_en = psel && penable && !pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            // error flag stands only beside the one-cycle pready pulse
            pslverr <= rd_en && !addr_ok;
            if (rd_en) begin
                case (paddr)
                    cttc_pkg::CTRL_ONE_ADDR: prdata <= {24'h00_0000, ctrl_q};
                    cttc_pkg::RUN_CTRL_ADDR: prdata <= {31'h0000_0000, counter_run_bit_q};
                    cttc_pkg::CMP_A_ADDR:    prdata <= {22'h00_0000, compare_a_value_q};
                    cttc_pkg::CMP_P_ADDR:    prdata <= {29'h0000_0000, compare_p_value_q};
                    cttc_pkg::STATUS_ADDR:   prdata <= {29'h0000_0000, compare_output_pin,
                                                        hit_p_q, hit_a_q};
                    cttc_pkg::COUNT_ADDR:    prdata <= {22'h00_0000, count_q};
                    default:                 prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register; all fields clear at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= cttc_pkg::CTRL_RESET;
        end else if (wr_en && paddr == cttc_pkg::CTRL_ONE_ADDR) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_run_bit_q <= 1'b0;
            compare_a_value_q <= cttc_pkg::CMP_RESET;
            compare_p_value_q <= cttc_pkg::CMPP_RESET;
        end else if (wr_en) begin
            if (paddr == cttc_pkg::RUN_CTRL_ADDR) begin
                counter_run_bit_q <= pwdata[0];
            end
            if (paddr == cttc_pkg::CMP_A_ADDR) begin
                compare_a_value_q <= pwdata[9:0];
            end
            if (paddr == cttc_pkg::CMP_P_ADDR) begin
                compare_p_value_q <= pwdata[2:0];
            end
        end
    end

    // comparators
    logic [9:0] p_full;
    logic [9:0] count_nx;
    logic       match_a;
    logic       match_p;
    logic       is_pwm;
    logic       is_cmp;
    logic       clr_cnt;
    logic       run_rise;
    assign p_full  = {compare_p_value_q, 7'h00};
    // match on the next count so a clear replaces that value: period equals the match value
    assign count_nx = count_q + 10'h001;
    assign match_a = counter_run_bit_q && (count_nx == compare_a_value_q)
                  && (compare_a_value_q != 10'h000);
    assign match_p = counter_run_bit_q && (count_nx[9:cttc_pkg::CMPP_SHIFT] == compare_p_value_q)
                  && (count_nx[cttc_pkg::CMPP_SHIFT-1:0] == 7'h00) && (compare_p_value_q != 3'h0);
    assign is_pwm  = (ctrl_q.op_mode_sel == cttc_pkg::MODE_PWM);
    assign is_cmp  = (ctrl_q.op_mode_sel == cttc_pkg::MODE_CMP);
    assign run_rise = counter_run_bit_q && !run_prev_q;

    // clearing: pwm uses swap bit, others the clear-source bit
    always_comb begin
        if (is_pwm) begin
            clr_cnt = ctrl_q.period_duty_swap ? match_a : match_p;
        end else if (ctrl_q.clear_source_sel) begin
            clr_cnt = match_a;
        end else begin
            clr_cnt = match_p; // overflow wrap only reaches 0 when P is zero
        end
    end

    // counter wraps naturally at 3ff; with P zero that is the overflow clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 10'h000;
        end else if (!counter_run_bit_q) begin
            count_q <= 10'h000;
        end else if (clr_cnt) begin
            count_q <= 10'h000;
        end else begin
            count_q <= count_q + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_prev_q    <= 1'b0;
            hit_a_q       <= 1'b0;
            hit_p_q       <= 1'b0;
            match_a_pulse <= 1'b0;
            match_p_pulse <= 1'b0;
        end else begin
            run_prev_q    <= counter_run_bit_q;
            match_a_pulse <= match_a;
            match_p_pulse <= match_p && (is_pwm || !ctrl_q.clear_source_sel);
            hit_a_q       <= match_a;
            hit_p_q       <= match_p;
        end
    end

    // compare-mode pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
        end else if (run_rise) begin
            level_q <= ctrl_q.pin_initial_level;
        end else if (is_cmp && match_a) begin
            case (ctrl_q.pin_action_sel)
                cttc_pkg::ACT_LOW:  level_q <= 1'b0;
                cttc_pkg::ACT_HIGH: level_q <= 1'b1;
                cttc_pkg::ACT_TOG:  level_q <= !level_q;
                default:            level_q <= level_q;
            endcase
        end
    end

    // pwm active phase: duty from the non-period register
    logic [9:0] duty_val;
    logic [10:0] period_val;
    assign duty_val   = ctrl_q.period_duty_swap ? p_full : compare_a_value_q;
    assign period_val = ctrl_q.period_duty_swap ? {1'b0, compare_a_value_q}
                      : ((compare_p_value_q == 3'h0) ? 11'h400 : {1'b0, p_full});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= counter_run_bit_q && (({1'b0, duty_val} >= period_val)
                                            || (count_q < duty_val));
        end
    end

    // pin mux: initial bit sets active level in pwm, polarity inverts
    logic pin_raw;
    always_comb begin
        pin_raw = level_q;
        if (is_pwm) begin
            case (ctrl_q.pin_action_sel)
                cttc_pkg::ACT_NONE: pin_raw = !ctrl_q.pin_initial_level;
                cttc_pkg::ACT_LOW:  pin_raw = ctrl_q.pin_initial_level;
                cttc_pkg::ACT_HIGH: pin_raw = pwm_q ~^ ctrl_q.pin_initial_level;
                default:            pin_raw = !ctrl_q.pin_initial_level;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_pin <= 1'b0;
            pin_enable         <= 1'b0;
        end else begin
            compare_output_pin <= pin_raw ^ ctrl_q.pin_polarity_invert;
            // timer mode and undefined mode leave the pin to other functions
            pin_enable         <= is_cmp || is_pwm;
        end
    end
endmodule

// file: sim/cttc_top_sva.sv
// checker: apb answers and pin relations of the compact timer
`timescale 1ns/1ns
module cttc_top_sva (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pin
    input wire logic        compare_output_pin,
    input wire logic        pin_enable,
    input wire logic        match_a_pulse,
    input wire logic        match_p_pulse
);
    logic [7:0] ctrl_q;
    logic       run_q;
    logic [1:0] sn_q;
    wire        acc = psel && penable && pready;
    wire        wr  = acc && pwrite && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) ctrl_q <= 8'h00;
        else if (wr && paddr == cttc_pkg::CTRL_ONE_ADDR) ctrl_q <= pwdata[7:0];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) run_q <= 1'h0;
        else if (wr && paddr == cttc_pkg::RUN_CTRL_ADDR) run_q <= pwdata[0];
    // settle count after a ctrl or run write; zero until the first one
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sn_q <= 2'h0;
        else if (wr && paddr[7:3] == 5'h00) sn_q <= 2'h1;
        else if (sn_q != 2'h0 && sn_q != 2'h3) sn_q <= sn_q + 2'h1;
    sequence s_run_rise;
        wr && paddr == cttc_pkg::RUN_CTRL_ADDR && pwdata[0] && !run_q && ctrl_q[7:6] == 2'h0;
    endsequence
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_unmapped_err: assert property (acc && paddr > 8'h14 |-> pslverr) else $error("no pslverr");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
    a_ctrl_read: assert property (
        acc && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, ctrl_q})
        else $error("ctrl readback wrong");
    a_pin_enable: assert property (
        sn_q == 2'h3 |-> pin_enable == !ctrl_q[6])
        else $error("pin enable wrong for mode");
    a_no_p_match: assert property (
        sn_q == 2'h3 && ctrl_q[7:6] != 2'h2 && ctrl_q[0] |-> !match_p_pulse)
        else $error("p match with a clear");
    a_pin_initial: assert property (
        s_run_rise ##3 1'h1 |-> compare_output_pin == (ctrl_q[3] ^ ctrl_q[2]))
        else $error("pin not at initial level");
    a_pwm_fixed: assert property (
        sn_q == 2'h3 && run_q && ctrl_q[7:5] == 3'h4 |->
        compare_output_pin == (ctrl_q[3] ^ ctrl_q[2] ^ !ctrl_q[4]))
        else $error("pwm fixed level wrong");
endmodule
bind cttc_top cttc_top_sva cttc_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_output_pin(compare_output_pin),
    .pin_enable(pin_enable), .match_a_pulse(match_a_pulse), .match_p_pulse(match_p_pulse));

// file: sim/testbench.sv
// testbench: apb stimulus and pin checks for the compact timer
`timescale 1ns/1ns
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, pin, pin_en, ma, mp;
    int          n_fail = 0, num_checks = 0, na, np, nh;
    cttc_top cttc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compare_output_pin(pin), .pin_enable(pin_en),
        .match_a_pulse(ma), .match_p_pulse(mp));
    always #5 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) chk(0, 1);
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic cfg(input logic [7:0] c, input logic [9:0] a, input logic [2:0] p);
        apb(1, 8'h04, 0);
        apb(1, 8'h08, {22'h0, a});
        apb(1, 8'h0C, {29'h0, p});
        apb(1, 8'h00, {24'h0, c});
        apb(1, 8'h04, 1);
        repeat (3) @(posedge pclk);
    endtask
    task automatic run_for(input int c);
        na = 0;
        np = 0;
        nh = 0;
        repeat (c) begin
            @(posedge pclk);
            na += (ma === 1'h1);
            np += (mp === 1'h1);
            nh += (pin === 1'h1);
        end
    endtask
    task automatic t_regs;
        apb(0, 8'h00, 0);
        chk(rd, 0);
        apb(1, 8'h00, 32'hA5);
        apb(0, 8'h00, 0);
        chk(rd, 32'hA5);
        apb(0, 8'h3C, 0);
        chk(rd, 0);
        chk({31'h0, er}, 1);
        for (int m = 0; m < 4; m++) begin
            apb(1, 8'h00, m << 6);
            // pin enable is registered one edge after the control write lands
            @(posedge pclk);
            chk(pin_en, m[0] == 0);
        end
    endtask
    task automatic t_cmp;
        logic [1:0] act;
        logic       init, pol, lvl;
        for (int i = 0; i < 8; i++) begin
            {init, act} = i[2:0];
            pol = i[1] ^ i[2];
            lvl = act == 2'h0 ? init : act == 2'h3 ? !init : act[1];
            cfg({2'h0, act, init, pol, 2'h1}, 10'h014, 3'h0);
            chk(pin, init ^ pol);
            for (int n = 0; n < 60 && ma !== 1'h1; n++) @(posedge pclk);
            repeat (3) @(posedge pclk);
            chk(pin, lvl ^ pol);
        end
    endtask
    task automatic t_clear;
        cfg(8'h30, 10'h0C8, 3'h1);
        run_for(600);
        chk(na, 0);
        chk(np >= 4, 1);
        chk(pin, 0);
        cfg(8'h31, 10'h0C8, 3'h1);
        run_for(600);
        chk(np, 0);
        chk(na >= 2, 1);
        cfg(8'h30, 10'h1F4, 3'h0);
        run_for(600);
        chk(np, 0);
        chk(na, 1);
    endtask
    task automatic t_pwm;
        logic [7:0] c [7] = '{8'hA8, 8'hA8, 8'hAA, 8'h98, 8'h88, 8'h8C, 8'hA0};
        logic [9:0] a [7] = '{10'h12C, 10'h020, 10'h064, 10'h020, 10'h020, 10'h020, 10'h020};
        int         e [7] = '{256, 64, 256, 256, 0, 256, 192};
        for (int i = 0; i < 7; i++) begin
            cfg(c[i], a[i], 3'h1);
            run_for(256);
            chk(nh, e[i]);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // run takes about 4200 cycles
    initial begin
        #500000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs;
        t_cmp;
        t_clear;
        t_pwm;
        tally_and_finish;
    end
endmodule
